// ==== shared/ddc_pkg.sv ====
/*
 Constants and types for the two-wide dispatch and completion controller.
 Assumes one core clock; all users import the whole package.
*/
package ddc_pkg;
	localparam int CQ_N    = 6;
	localparam int REN_N   = 6;
	localparam int UNIT_N  = 5;
	localparam int SLOT_N  = 2;
	localparam int LSU_RS  = 2;
	localparam int UNIT_RS = 1;
	localparam logic [1:0] PRED_MAX = 2'h2;
	localparam logic [2:0] U_IU1 = 3'h0;
	localparam logic [2:0] U_IU2 = 3'h1;
	localparam logic [2:0] U_FPU = 3'h2;
	localparam logic [2:0] U_SRU = 3'h3;
	localparam logic [2:0] U_LSU = 3'h4;
	localparam logic [1:0] SER_NONE    = 2'h0;
	localparam logic [1:0] SER_EXEC    = 2'h1;
	localparam logic [1:0] SER_COMP    = 2'h2;
	localparam logic [1:0] SER_REFETCH = 2'h3;
	typedef enum logic [3:0] {
		F_RUN    = 4'h1,
		F_BRANCH_TARGET_INSTR_CACHE   = 4'h2,
		F_IDLE   = 4'h4,
		F_ICACHE = 4'h8
	} ddc_fetch_e;
endpackage

// ==== verilog/ddc_rename_pool.sv ====
/*
 Six-entry rename buffer pool: hands out up to two free tags per cycle.
 Assumes the caller never allocates more than free_cnt.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_rename_pool
	import ddc_pkg::*;
(
	input  wire logic             clk,       // core clock
	input  wire logic             nrst,      // sync reset, low
	input  wire logic [1:0]       alloc_n,   // tags taken this cycle
	input  wire logic [REN_N-1:0] free_mask, // tags released
	output logic      [2:0]       free_cnt,  // free buffers
	output logic      [2:0]       tag0,      // first free tag
	output logic      [2:0]       tag1       // second free tag
);
	typedef struct packed {
		logic [REN_N-1:0] busy;
	} ddc_pool_s;

	ddc_pool_s s;
	ddc_pool_s next_s;

	function automatic logic [2:0] ddc_first(input logic [REN_N-1:0] m);
		ddc_first = 3'h0;
		for (int i = REN_N - 1; i >= 0; i--) begin
			if (!m[i]) begin
				ddc_first = 3'(i);
			end
		end
	endfunction

	always_comb begin
		tag0     = ddc_first(s.busy);
		tag1     = ddc_first(s.busy | (REN_N'(1) << tag0));
		free_cnt = 3'(REN_N - $countones(s.busy));
		next_s.busy = s.busy & ~free_mask;
		// Tags come from the old map, so a freed tag is not reused at once
		if (alloc_n != 2'h0) begin
			next_s.busy[tag0] = 1'b1;
		end
		if (alloc_n == 2'h2) begin
			next_s.busy[tag1] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/ddc_dispatch_core.sv ====
/*
 Dispatch, reservation stations, completion queue, renaming and
 branch folding control. Assumes decode supplies per-slot attributes
 and execution units report finish by completion queue index.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_dispatch_core
	import ddc_pkg::*;
(
	input  wire logic                        clk,         // core clock
	input  wire logic                        nrst,        // sync reset, low
	input  wire logic [SLOT_N-1:0]           slot_v,      // slot holds instr
	input  wire logic [SLOT_N-1:0][2:0]      slot_unit,   // target unit
	input  wire logic [SLOT_N-1:0][1:0]      slot_ser,    // serialization
	input  wire logic [SLOT_N-1:0]           slot_br,     // is a branch
	input  wire logic [SLOT_N-1:0]           slot_brlink, // branch writes lr/ctr
	input  wire logic [SLOT_N-1:0]           slot_pred,   // unresolved, predicted
	input  wire logic [SLOT_N-1:0]           slot_gw,     // writes gpr
	input  wire logic [SLOT_N-1:0]           slot_fw,     // writes fpr
	input  wire logic [SLOT_N-1:0][2:0]      slot_spr,    // writes cr,lr,ctr
	input  wire logic [SLOT_N-1:0]           slot_wait,   // operand pending
	input  wire logic [SLOT_N-1:0][3:0]      slot_src,    // awaited rename tag
	output logic      [SLOT_N-1:0]           slot_take,   // slot dispatched
	input  wire logic [UNIT_N-1:0]           unit_busy,   // unit cannot start
	input  wire logic                        wb_v,        // rename data written
	input  wire logic [3:0]                  wb_tag,      // its tag
	output logic      [UNIT_N-1:0]           unit_start,  // start execution
	output logic      [UNIT_N-1:0][2:0]      start_idx,   // queue index
	output logic      [UNIT_N-1:0][7:0]      start_dst,   // {gv,gt,fv,ft}
	input  wire logic [1:0]                  fin_v,       // unit finished
	input  wire logic [1:0][2:0]             fin_idx,     // its queue index
	input  wire logic [1:0]                  fin_exc,     // it faulted
	input  wire logic                        res_v,       // oldest branch resolved
	input  wire logic                        res_ok,      // prediction right
	input  wire logic                        fold_taken,  // taken branch folded
	input  wire logic                        branch_target_instr_cache_hit,    // target cache hit
	input  wire logic                        icache_inv,  // flash invalidate
	input  wire logic                        icbi_exec,   // block invalidate op
	input  wire logic                        rfi_exec,    // interrupt return
	output logic      [1:0]                  ret_v,       // retired
	output logic      [1:0]                  ret_gw,      // gpr commit
	output logic      [1:0][2:0]             ret_gt,      // gpr rename tag
	output logic      [1:0]                  ret_fw,      // fpr commit
	output logic      [1:0][2:0]             ret_ft,      // fpr rename tag
	output logic      [1:0][2:0]             ret_spr,     // cr,lr,ctr commit
	output logic                             exc_taken,   // go to handler
	output logic                             refetch,     // refetch younger
	output logic                             redirect,    // fetch other path
	output logic                             branch_target_instr_cache_inv,    // clear target cache
	output logic                             fetch_hold,  // two unresolved
	output logic                             fetch_branch_target_instr_cache,  // two cached targets
	output logic                             fetch_icache,// four from icache
	output logic                             fetch_idle   // idle fetch cycle
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [CQ_N-1:0]              cq_v, cq_done, cq_exc, cq_ser;
		logic [CQ_N-1:0]              cq_gv, cq_fv;
		logic [CQ_N-1:0][1:0]         cq_lvl;
		logic [CQ_N-1:0][2:0]         cq_gt, cq_ft, cq_spr;
		logic [2:0]                   head;
		logic [UNIT_N-1:0][1:0]       rs_v, rs_w, rs_xs;
		logic [UNIT_N-1:0][1:0][3:0]  rs_src;
		logic [UNIT_N-1:0][1:0][2:0]  rs_idx;
		logic [UNIT_N-1:0][1:0][7:0]  rs_dst;
		logic [2:0]                   spr_busy;
		logic [1:0]                   unres;
		logic                         blk, blk_rf;
		logic [2:0]                   blk_idx;
		ddc_fetch_e                   fst;
		logic [1:0]                   ret_v, ret_gw, ret_fw;
		logic [1:0][2:0]              ret_gt, ret_ft, ret_spr;
		logic                         exc, rfch, redir, binv;
	} ddc_core_s;

	ddc_core_s        s;
	ddc_core_s        next_s;
	logic [CQ_N-1:0]  kill;
	logic [REN_N-1:0] gfree, ffree;
	logic [1:0]       galloc, falloc;
	logic [2:0]       gcnt, gtag0, gtag1, fcnt, ftag0, ftag1;

	function automatic logic [2:0] ddc_wrap(input logic [2:0] a,
		input logic [2:0] b);
		logic [3:0] t;
		t = {1'b0, a} + {1'b0, b};
		ddc_wrap = (t >= 4'(CQ_N)) ? 3'(t - 4'(CQ_N)) : t[2:0];
	endfunction

	function automatic logic [1:0] ddc_room(input logic [2:0] u,
		input logic [1:0] v, input logic x);
		logic [1:0] cap;
		cap = (u == U_LSU) ? 2'(LSU_RS) : 2'(UNIT_RS);
		// A held execution-serialized op closes the unit to new work
		ddc_room = x ? 2'h0 : cap - {1'b0, v[0]} - {1'b0, v[1]};
	endfunction

	// ---------------------------------------------------------------
	// Rename pools
	// ---------------------------------------------------------------
	ddc_rename_pool u_gpr_pool (
		.clk       (clk),
		.nrst      (nrst),
		.alloc_n   (galloc),
		.free_mask (gfree),
		.free_cnt  (gcnt),
		.tag0      (gtag0),
		.tag1      (gtag1)
	);
	ddc_rename_pool u_fpr_pool (
		.clk       (clk),
		.nrst      (nrst),
		.alloc_n   (falloc),
		.free_mask (ffree),
		.free_cnt  (fcnt),
		.tag0      (ftag0),
		.tag1      (ftag1)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [2:0] ix, occ, tail, u;
		logic [1:0] cused;
		logic       ok, prev, fold, rdy, p;
		ix = 3'h0; occ = 3'h0; tail = 3'h0; u = 3'h0; cused = 2'h0;
		ok = 1'b0; prev = 1'b1; fold = 1'b0; rdy = 1'b0; p = 1'b0;
		next_s = s;
		next_s.ret_v = 2'h0;
		next_s.ret_gw = 2'h0;
		next_s.ret_fw = 2'h0;
		next_s.exc = 1'b0;
		next_s.rfch = 1'b0;
		next_s.redir = 1'b0;
		next_s.binv = icache_inv | icbi_exec | rfi_exec;
		kill = '0; gfree = '0; ffree = '0;
		galloc = 2'h0; falloc = 2'h0;
		slot_take = '0; unit_start = '0;
		for (int k = 0; k < 2; k++) begin
			if (fin_v[k] && s.cq_v[fin_idx[k]]) begin
				next_s.cq_done[fin_idx[k]] = 1'b1;
				next_s.cq_exc[fin_idx[k]] = fin_exc[k];
			end
		end
		if (res_v && res_ok) begin
			for (int e = 0; e < CQ_N; e++) begin
				if (s.cq_lvl[e] != 2'h0) begin
					next_s.cq_lvl[e] = s.cq_lvl[e] - 2'h1;
				end
			end
			next_s.unres = s.unres - 2'h1;
		end else if (res_v) begin
			for (int e = 0; e < CQ_N; e++) begin
				kill[e] = s.cq_v[e] && s.cq_lvl[e] != 2'h0;
			end
			next_s.unres = 2'h0;
			next_s.redir = 1'b1;
		end
		// Retire: in order, up to two, held by speculation or fault
		for (int k = 0; k < 2; k++) begin
			ix = ddc_wrap(s.head, 3'(k));
			ok = prev && next_s.cq_v[ix] && next_s.cq_done[ix] &&
				!next_s.cq_exc[ix] && next_s.cq_lvl[ix] == 2'h0;
			if (k == 1) begin
				ok = ok && !s.cq_ser[ix] && !s.cq_ser[s.head];
			end
			if (ok) begin
				next_s.cq_v[ix] = 1'b0;
				next_s.ret_v[k] = 1'b1;
				next_s.ret_gw[k] = s.cq_gv[ix];
				next_s.ret_gt[k] = s.cq_gt[ix];
				next_s.ret_fw[k] = s.cq_fv[ix];
				next_s.ret_ft[k] = s.cq_ft[ix];
				next_s.ret_spr[k] = s.cq_spr[ix];
				// Merge, so an entry without a result cannot undo a release
				gfree[s.cq_gt[ix]] = gfree[s.cq_gt[ix]] | s.cq_gv[ix];
				ffree[s.cq_ft[ix]] = ffree[s.cq_ft[ix]] | s.cq_fv[ix];
				next_s.spr_busy = next_s.spr_busy & ~s.cq_spr[ix];
				next_s.head = ddc_wrap(ix, 3'h1);
				if (s.blk && ix == s.blk_idx) begin
					next_s.blk = 1'b0;
					next_s.rfch = s.blk_rf;
				end
			end
			prev = ok;
		end
		ix = s.head;
		if (next_s.cq_v[ix] && next_s.cq_done[ix] && next_s.cq_exc[ix] &&
			next_s.cq_lvl[ix] == 2'h0) begin
			next_s.exc = 1'b1;
			next_s.binv = 1'b1;
			kill = s.cq_v;
			next_s.unres = 2'h0;
			next_s.blk = 1'b0;
		end
		for (int e = 0; e < CQ_N; e++) begin
			if (kill[e]) begin
				next_s.cq_v[e] = 1'b0;
				gfree[s.cq_gt[e]] = gfree[s.cq_gt[e]] | s.cq_gv[e];
				ffree[s.cq_ft[e]] = ffree[s.cq_ft[e]] | s.cq_fv[e];
				next_s.spr_busy = next_s.spr_busy & ~s.cq_spr[e];
			end
		end
		// ---------------------------------------------------------------
		// Reservation stations
		// ---------------------------------------------------------------
		for (int x = 0; x < UNIT_N; x++) begin
			for (int j = 0; j < 2; j++) begin
				next_s.rs_w[x][j] = s.rs_w[x][j] &&
					!(wb_v && wb_tag == s.rs_src[x][j]);
				if (kill[s.rs_idx[x][j]]) begin
					next_s.rs_v[x][j] = 1'b0;
				end
			end
			// Start in the very cycle the awaited rename data lands
			rdy = next_s.rs_v[x][0] && !next_s.rs_w[x][0] &&
				!unit_busy[x] && (!s.rs_xs[x][0] ||
				s.rs_idx[x][0] == s.head);
			unit_start[x] = rdy;
			if (rdy) begin
				next_s.rs_v[x][0] = next_s.rs_v[x][1];
				next_s.rs_w[x][0] = next_s.rs_w[x][1];
				next_s.rs_xs[x][0] = s.rs_xs[x][1];
				next_s.rs_src[x][0] = s.rs_src[x][1];
				next_s.rs_idx[x][0] = s.rs_idx[x][1];
				next_s.rs_dst[x][0] = s.rs_dst[x][1];
				next_s.rs_v[x][1] = 1'b0;
			end
		end
		// ---------------------------------------------------------------
		// Dispatch
		// ---------------------------------------------------------------
		occ = 3'($countones(s.cq_v));
		tail = ddc_wrap(s.head, occ);
		for (int k = 0; k < SLOT_N; k++) begin
			u = slot_unit[k];
			fold = slot_br[k] && !slot_brlink[k];
			// Stall on flush cycles: queue positions are being rewritten
			ok = slot_v[k] && !s.blk && kill == '0 && !next_s.exc &&
				!next_s.redir &&
				next_s.unres != PRED_MAX && (fold ||
				({1'b0, cused} < 3'(CQ_N) - occ)) &&
				(!slot_gw[k] || {1'b0, galloc} < gcnt) &&
				(!slot_fw[k] || {1'b0, falloc} < fcnt) &&
				(slot_spr[k] & next_s.spr_busy) == 3'h0 && (slot_br[k] ||
				ddc_room(u, next_s.rs_v[u], next_s.rs_xs[u][0]) != 2'h0);
			if (k == 1) begin
				ok = ok && slot_take[0] && slot_ser[0] == SER_NONE &&
					slot_ser[1] == SER_NONE;
			end
			slot_take[k] = ok;
			if (ok && !fold) begin
				ix = ddc_wrap(tail, {1'b0, cused});
				cused = cused + 2'h1;
				next_s.cq_v[ix] = 1'b1;
				next_s.cq_done[ix] = slot_br[k];
				next_s.cq_exc[ix] = 1'b0;
				next_s.cq_ser[ix] = slot_ser[k] != SER_NONE;
				next_s.cq_lvl[ix] = next_s.unres;
				next_s.cq_gv[ix] = slot_gw[k];
				next_s.cq_gt[ix] = (galloc == 2'h0) ? gtag0 : gtag1;
				next_s.cq_fv[ix] = slot_fw[k];
				next_s.cq_ft[ix] = (falloc == 2'h0) ? ftag0 : ftag1;
				next_s.cq_spr[ix] = slot_spr[k];
				next_s.spr_busy = next_s.spr_busy | slot_spr[k];
				galloc = galloc + {1'b0, slot_gw[k]};
				falloc = falloc + {1'b0, slot_fw[k]};
				if (!slot_br[k]) begin
					p = next_s.rs_v[u][0];
					next_s.rs_v[u][p] = 1'b1;
					next_s.rs_w[u][p] = slot_wait[k];
					next_s.rs_src[u][p] = slot_src[k];
					next_s.rs_idx[u][p] = ix;
					next_s.rs_xs[u][p] = slot_ser[k] == SER_EXEC;
					next_s.rs_dst[u][p] = {slot_gw[k], next_s.cq_gt[ix],
						slot_fw[k], next_s.cq_ft[ix]};
				end
				if (slot_ser[k] == SER_COMP || slot_ser[k] == SER_REFETCH) begin
					next_s.blk = 1'b1;
					next_s.blk_rf = slot_ser[k] == SER_REFETCH;
					next_s.blk_idx = ix;
				end
			end
			// Predicted branch adds one unresolved speculation level
			if (ok && slot_pred[k]) begin
				next_s.unres = next_s.unres + 2'h1;
			end
		end
		// ---------------------------------------------------------------
		// Folded-branch fetch sequencing
		// ---------------------------------------------------------------
		case (s.fst)
			F_RUN: begin
				if (fold_taken) begin
					next_s.fst = branch_target_instr_cache_hit ? F_BRANCH_TARGET_INSTR_CACHE : F_IDLE;
				end
			end
			F_BRANCH_TARGET_INSTR_CACHE, F_IDLE: begin
				next_s.fst = F_ICACHE;
			end
			default: begin
				next_s.fst = F_RUN;
			end
		endcase
		if (next_s.redir || next_s.exc) begin
			next_s.fst = F_RUN;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= '0;
			s.fst <= F_RUN;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		for (int x = 0; x < UNIT_N; x++) begin
			start_idx[x] = s.rs_idx[x][0];
			start_dst[x] = s.rs_dst[x][0];
		end
	end

	assign ret_v        = s.ret_v;
	assign ret_gw       = s.ret_gw;
	assign ret_gt       = s.ret_gt;
	assign ret_fw       = s.ret_fw;
	assign ret_ft       = s.ret_ft;
	assign ret_spr      = s.ret_spr;
	assign exc_taken    = s.exc;
	assign refetch      = s.rfch;
	assign redirect     = s.redir;
	assign branch_target_instr_cache_inv     = s.binv;
	assign fetch_hold   = s.unres == PRED_MAX;
	assign fetch_branch_target_instr_cache   = s.fst == F_BRANCH_TARGET_INSTR_CACHE;
	assign fetch_icache = s.fst == F_ICACHE;
	assign fetch_idle   = s.fst == F_IDLE;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking ddc_cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_ser_single: assert property (
		slot_take[1] |-> slot_ser == 4'h0) else $error("serial pair");
	chk_cq_full: assert property (
		(&s.cq_v) && !slot_br[0] |-> !slot_take[0])
		else $error("dispatch into full queue");
	chk_exc_head: assert property (
		s.cq_v[s.head] && s.cq_done[s.head] && s.cq_exc[s.head] &&
		s.cq_lvl[s.head] == 2'h0 |=> exc_taken && branch_target_instr_cache_inv && s.cq_v == '0)
		else $error("exception not taken");
	chk_rs_wake: assert property (
		s.rs_v[U_FPU][0] && wb_v && wb_tag == s.rs_src[U_FPU][0] &&
		!unit_busy[U_FPU] && !s.rs_xs[U_FPU][0] && kill == '0
		|-> unit_start[U_FPU]) else $error("late wake");
	chk_xs_hold: assert property (
		s.rs_v[U_SRU][0] && s.rs_xs[U_SRU][0] &&
		s.rs_idx[U_SRU][0] != s.head |-> !unit_start[U_SRU])
		else $error("serialized op started early");
	chk_blk_dispatch: assert property (
		s.blk |-> slot_take == 2'h0) else $error("dispatch while blocked");
	chk_branch_target_instr_cache_path: assert property (
		s.fst == F_RUN && fold_taken && branch_target_instr_cache_hit && !res_v && !next_s.exc
		|=> fetch_branch_target_instr_cache ##1 (fetch_icache || redirect || exc_taken))
		else $error("hit path timing");
	chk_miss_idle: assert property (
		s.fst == F_RUN && fold_taken && !branch_target_instr_cache_hit && !res_v && !next_s.exc
		|=> fetch_idle ##1 (fetch_icache || redirect || exc_taken))
		else $error("miss path timing");
	chk_mispredict: assert property (
		res_v && !res_ok |=> redirect && s.unres == 2'h0)
		else $error("mispredict not flushed");
	chk_third_branch: assert property (
		s.unres == PRED_MAX && !res_v |-> slot_take == 2'h0 && fetch_hold)
		else $error("third level dispatched");
	chk_retire_order: assert property (
		ret_v[1] |-> ret_v[0]) else $error("out of order retire");
endmodule
`default_nettype wire

// ==== testbench/ddc_exec_model.sv ====
/*
 Behavioural execution units standing beyond the dispatch controller.
 Assumes one core clock; latency, faults and stalls come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ddc_exec_model
	import ddc_pkg::*;
(
	input  wire logic                   clk,        // core clock
	input  wire logic                   nrst,       // sync reset, low
	input  wire logic [UNIT_N-1:0]      unit_start, // start pulses
	input  wire logic [UNIT_N-1:0][2:0] start_idx,  // queue index
	input  wire logic [UNIT_N-1:0][3:0] lat,        // cycles to finish
	input  wire logic [UNIT_N-1:0]      fault,      // finish faulted
	input  wire logic [UNIT_N-1:0]      stall,      // hold unit busy
	output logic      [UNIT_N-1:0]      unit_busy,  // cannot start
	output logic      [1:0]             fin_v,      // finish pulse
	output logic      [1:0][2:0]        fin_idx,    // its index
	output logic      [1:0]             fin_exc     // it faulted
);
	logic [UNIT_N-1:0][3:0] cnt;
	logic [UNIT_N-1:0][2:0] idx;
	// No pipelining: a unit is busy until its one op finishes
	always_comb begin
		for (int u = 0; u < UNIT_N; u++) begin
			unit_busy[u] = stall[u] | (cnt[u] != 4'h0);
		end
	end
	// Two finish ports; a third finisher waits a cycle
	always_ff @(posedge clk) begin
		int k;
		k = 0;
		fin_v   <= 2'h0;
		fin_idx <= ~fin_idx;
		fin_exc <= ~fin_exc;
		for (int u = 0; u < UNIT_N; u++) begin
			if (!nrst) begin
				cnt[u] <= 4'h0;
			end else if (unit_start[u]) begin
				cnt[u] <= lat[u];
				idx[u] <= start_idx[u];
			end else if (cnt[u] == 4'h1 && k < 2) begin
				cnt[u]     <= 4'h0;
				fin_v[k]   <= 1'b1;
				fin_idx[k] <= idx[u];
				fin_exc[k] <= fault[u];
				k = k + 1;
			end else if (cnt[u] > 4'h1) begin
				cnt[u] <= cnt[u] - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/dual_issue_dispatch_completion_bench.sv ====
/*
 Self-checking bench for the dispatch and completion controller.
 Assumes the execution model answers for units; 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_issue_dispatch_completion_bench;
	import ddc_pkg::*;
	logic clk, nrst, wb_v, res_v, res_ok, fold_taken, branch_target_instr_cache_hit;
	logic icache_inv, icbi_exec, rfi_exec, exc_taken, refetch, redirect;
	logic branch_target_instr_cache_inv, fetch_hold, fetch_branch_target_instr_cache, fetch_icache, fetch_idle;
	logic [1:0] slot_v, slot_br, slot_brlink, slot_pred, slot_gw, slot_fw;
	logic [1:0] slot_wait, slot_take, fin_v, fin_exc, ret_v, ret_gw, ret_fw;
	logic [1:0][2:0] slot_unit, slot_spr, fin_idx, ret_gt, ret_ft, ret_spr;
	logic [1:0][1:0] slot_ser;
	logic [1:0][3:0] slot_src;
	logic [3:0] wb_tag;
	logic [4:0] unit_busy, unit_start, fault, stall;
	logic [4:0][2:0] start_idx;
	logic [4:0][7:0] start_dst;
	logic [4:0][3:0] lat;
	int bad_count, checked, tot;
	ddc_dispatch_core uut (.clk, .nrst, .slot_v, .slot_unit, .slot_ser,
		.slot_br, .slot_brlink, .slot_pred, .slot_gw, .slot_fw, .slot_spr,
		.slot_wait, .slot_src, .slot_take, .unit_busy, .wb_v, .wb_tag,
		.unit_start, .start_idx, .start_dst, .fin_v, .fin_idx, .fin_exc,
		.res_v, .res_ok, .fold_taken, .branch_target_instr_cache_hit, .icache_inv, .icbi_exec,
		.rfi_exec, .ret_v, .ret_gw, .ret_gt, .ret_fw, .ret_ft, .ret_spr,
		.exc_taken, .refetch, .redirect, .branch_target_instr_cache_inv, .fetch_hold,
		.fetch_branch_target_instr_cache, .fetch_icache, .fetch_idle);
	ddc_exec_model units (.clk, .nrst, .unit_start, .start_idx, .lat,
		.fault, .stall, .unit_busy, .fin_v, .fin_idx, .fin_exc);
	always #10 clk = ~clk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task tally_and_finish;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [2:0] e, input logic [2:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task step;
		@(posedge clk);
	endtask
	// Slot fields for a plain op or a branch; f = {br, link, pred}
	task put(input int k, input logic [2:0] u, input logic [1:0] s,
		input logic [2:0] f);
		slot_v[k]      <= 1'b1;
		slot_unit[k]   <= u;
		slot_ser[k]    <= s;
		slot_br[k]     <= f[2];
		slot_brlink[k] <= f[1];
		slot_pred[k]   <= f[0];
		slot_gw[k]     <= !f[2] && u != U_FPU;
		slot_fw[k]     <= !f[2] && u == U_FPU;
		slot_spr[k]    <= f[1] ? 3'h2 : 3'h0;
	endtask
	task go(input logic [1:0] e);
		@(negedge clk);
		chk("slot_take", {1'b0, e}, {1'b0, slot_take});
		@(posedge clk);
		slot_v <= 2'h0;
	endtask
	task no_ret(input int n);
		repeat (n) begin
			@(negedge clk);
			chk("ret_v", 3'h0, {1'b0, ret_v});
		end
	endtask
	function logic pick(input int w);
		case (w)
			0: return ret_v[0];
			default: return exc_taken;
		endcase
	endfunction
	task wait_for(input int w);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pick(w) !== 1'b1 && n < 40);
		if (pick(w) !== 1'b1) begin
			bad_count++;
			$display("[ERR] wait %0d expected 1 seen 0", w);
			tally_and_finish;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task sc_pair;
		step;
		put(0, U_IU1, SER_NONE, 3'h0);
		put(1, U_FPU, SER_NONE, 3'h0);
		go(2'h3);
		wait_for(0);
		chk("ret_v", 3'h3, {1'b0, ret_v});
		chk("ret_fw", 3'h2, {1'b0, ret_fw});
		chk("ret_gw", 3'h1, {1'b0, ret_gw});
		chk("ret_gt0", 3'h0, ret_gt[0]);
		chk("ret_ft1", 3'h0, ret_ft[1]);
	endtask
	task sc_xser;
		lat[U_IU1] <= 4'h8;
		step;
		put(0, U_IU1, SER_NONE, 3'h0);
		go(2'h1);
		step;
		put(0, U_SRU, SER_EXEC, 3'h0);
		go(2'h1);
		step;
		put(0, U_SRU, SER_NONE, 3'h0);
		go(2'h0);
		no_ret(3);
		chk("xs start", 3'h0, {2'h0, unit_start[U_SRU]});
		lat[U_IU1] <= 4'h2;
		repeat (20) step;
	endtask
	task sc_fetch;
		for (int h = 0; h < 2; h++) begin
			step;
			fold_taken <= 1'b1;
			branch_target_instr_cache_hit   <= h[0];
			step;
			fold_taken <= 1'b0;
			@(negedge clk);
			chk("fetch_branch_target_instr_cache", {2'h0, h[0]}, {2'h0, fetch_branch_target_instr_cache});
			chk("fetch_idle", {2'h0, !h[0]}, {2'h0, fetch_idle});
			@(negedge clk);
			chk("fetch_icache", 3'h1, {2'h0, fetch_icache});
		end
		for (int i = 0; i < 3; i++) begin
			step;
			{rfi_exec, icbi_exec, icache_inv} <= 3'h1 << i;
			step;
			{rfi_exec, icbi_exec, icache_inv} <= 3'h0;
			@(negedge clk);
			chk("branch_target_instr_cache_inv", 3'h1, {2'h0, branch_target_instr_cache_inv});
		end
	endtask
	task sc_wait;
		step;
		put(0, U_IU2, SER_NONE, 3'h0);
		slot_wait   <= 2'h1;
		slot_src[0] <= 4'h5;
		go(2'h1);
		step;
		slot_wait <= 2'h0;
		put(0, U_IU1, SER_NONE, 3'h0);
		go(2'h1);
		repeat (3) begin
			@(negedge clk);
			chk("held start", 3'h0, {2'h0, unit_start[U_IU2]});
		end
		step;
		wb_v   <= 1'b1;
		wb_tag <= 4'h5;
		@(negedge clk);
		chk("wb start", 3'h1, {2'h0, unit_start[U_IU2]});
		step;
		wb_v <= 1'b0;
		repeat (12) step;
	endtask
	task sc_serial;
		step;
		put(0, U_IU1, SER_COMP, 3'h0);
		put(1, U_FPU, SER_NONE, 3'h0);
		go(2'h1);
		step;
		put(0, U_FPU, SER_NONE, 3'h0);
		go(2'h0);
		wait_for(0);
		step;
		put(0, U_IU2, SER_REFETCH, 3'h0);
		go(2'h1);
		wait_for(0);
		chk("refetch", 3'h1, {2'h0, refetch});
	endtask
	task sc_fold;
		step;
		put(0, U_IU1, SER_NONE, 3'h4);
		go(2'h1);
		no_ret(5);
		step;
		put(0, U_IU1, SER_NONE, 3'h6);
		go(2'h1);
		wait_for(0);
		chk("ret_spr", 3'h2, ret_spr[0]);
	endtask
	task sc_full;
		logic [2:0] us [6];
		us = '{U_IU1, U_IU2, U_FPU, U_SRU, U_LSU, U_LSU};
		stall <= 5'h1F;
		foreach (us[i]) begin
			step;
			put(0, us[i], SER_NONE, 3'h0);
			go(2'h1);
		end
		step;
		put(0, U_IU1, SER_NONE, 3'h6);
		go(2'h0);
		stall <= 5'h0;
		tot = 0;
		repeat (40) begin
			@(negedge clk);
			tot += ret_v[0] + ret_v[1];
		end
		chk("retired", 3'h6, tot[2:0]);
	endtask
	task sc_exc;
		step;
		lat[U_IU1] <= 4'h8;
		fault      <= 5'h02;
		put(0, U_IU1, SER_NONE, 3'h0);
		put(1, U_IU2, SER_NONE, 3'h0);
		go(2'h3);
		wait_for(0);
		chk("exc early", 3'h0, {2'h0, exc_taken});
		wait_for(1);
		chk("branch_target_instr_cache_inv", 3'h1, {2'h0, branch_target_instr_cache_inv});
		chk("ret_v", 3'h0, {1'b0, ret_v});
		fault      <= 5'h0;
		lat[U_IU1] <= 4'h2;
		repeat (4) step;
	endtask
	task sc_branch;
		repeat (2) begin
			step;
			put(0, U_IU1, SER_NONE, 3'h5);
			go(2'h1);
		end
		@(negedge clk);
		chk("fetch_hold", 3'h1, {2'h0, fetch_hold});
		step;
		put(0, U_IU1, SER_NONE, 3'h5);
		go(2'h0);
		step;
		res_v  <= 1'b1;
		res_ok <= 1'b1;
		step;
		res_v <= 1'b0;
		step;
		put(0, U_IU1, SER_NONE, 3'h0);
		go(2'h1);
		no_ret(6);
		step;
		res_v  <= 1'b1;
		res_ok <= 1'b0;
		step;
		res_v <= 1'b0;
		@(negedge clk);
		chk("redirect", 3'h1, {2'h0, redirect});
		no_ret(8);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{clk, nrst, wb_v, res_v, res_ok, fold_taken, branch_target_instr_cache_hit} = 7'h0;
		{icache_inv, icbi_exec, rfi_exec, wb_tag} = 7'h0;
		{slot_v, slot_br, slot_brlink, slot_pred, slot_gw, slot_fw} = 12'h0;
		{slot_unit, slot_spr, slot_ser, slot_wait, slot_src} = 26'h0;
		{fault, stall} = 10'h0;
		lat = {5{4'h2}};
		bad_count = 0;
		checked = 0;
		repeat (8) step;
		nrst <= 1'b1;
		sc_pair;
		sc_fetch;
		sc_wait;
		sc_serial;
		sc_xser;
		sc_fold;
		sc_full;
		sc_exc;
		sc_branch;
		tally_and_finish;
	end
endmodule
`default_nettype wire
